/* File: delay_info_consts.vh */
// constants for the single-trip delay information register bank
// assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock
`ifndef DELAY_INFO_CONSTS_VH
`define DELAY_INFO_CONSTS_VH
`define ADDR_W            8
`define OFF_TARGET        8'h64
`define OFF_TX_LOC        8'h68
`define OFF_RX_LOC        8'h6c
`define OFF_OVERRIDE      8'h70
`define MASK_TARGET       32'h01ff_00ff
`define MASK_LOC          32'h0001_7fff
`define MASK_OVERRIDE     32'h0001_0fff
`define RESET_WORD        32'h0000_0000
`define BIT_ENABLE        16
`define SEQ_HI            14
`define SEQ_LO            8
`define FRAME_HI          7
`define FRAME_LO          0
`define CYC_HI            7
`define CYC_LO            0
`define STEP_HI           24
`define STEP_LO           16
`define USR_HI            11
`define USR_LO            0
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10
`endif

/* File: masked_word_reg.v */
// one software word with a writable-bit mask and byte strobes
// assumes the caller decodes the address into wrHit
`timescale 1ns/100ps
`include "delay_info_consts.vh"
module masked_word_reg #(
	parameter [31:0] MASK = 32'hffff_ffff
) (
	input  wire        clk,
	input  wire        srst,
	input  wire        wrHit,
	input  wire [31:0] wrData,
	input  wire [3:0]  wrStrb,
	output reg  [31:0] word_reg
);
	reg  [31:0] word_next;
	integer i;
	always @* begin
		word_next = word_reg;
		if (wrHit) begin
			for (i = 0; i < 4; i = i + 1) begin
				if (wrStrb[i]) begin
					word_next[i*8 +: 8] = wrData[i*8 +: 8];
				end
			end
		end
		word_next = word_next & MASK;
	end
	always @(posedge clk) begin
		if (srst) begin
			word_reg <= `RESET_WORD;
		end else begin
			word_reg <= word_next;
		end
	end
endmodule // masked_word_reg

/* File: axil_bus_slave.v */
// axi4-lite slave front end: takes one write and one read, answers each once
// assumes a well-behaved master; address/data taken in either order
`timescale 1ns/100ps
`include "delay_info_consts.vh"
module axil_bus_slave (
	input  wire               clk,
	input  wire               srst,
	input  wire [`ADDR_W-1:0] awaddr,
	input  wire               awvalid,
	output reg                awready,
	input  wire [31:0]        wdata,
	input  wire [3:0]         wstrb,
	input  wire               wvalid,
	output reg                wready,
	output reg  [1:0]         bresp,
	output reg                bvalid,
	input  wire               bready,
	input  wire [`ADDR_W-1:0] araddr,
	input  wire               arvalid,
	output reg                arready,
	output reg  [31:0]        rdata,
	output reg  [1:0]         rresp,
	output reg                rvalid,
	input  wire               rready,
	output wire               wrFire,
	output wire [`ADDR_W-1:0] wrAddr,
	output wire [31:0]        wrData,
	output wire [3:0]         wrStrb,
	input  wire               wrOk,
	output wire [`ADDR_W-1:0] rdAddr,
	input  wire [31:0]        rdWord,
	input  wire               rdOk
);
	reg  [`ADDR_W-1:0] awHold_reg;
	reg  [31:0]        wHold_reg;
	reg  [3:0]         sHold_reg;
	reg                awHave_reg;
	reg                wHave_reg;
	wire awTake = awvalid & awready;
	wire wTake  = wvalid & wready;
	assign wrFire = awHave_reg & wHave_reg & ~bvalid;
	assign wrAddr = awHold_reg;
	assign wrData = wHold_reg;
	assign wrStrb = sHold_reg;
	assign rdAddr = araddr;
	always @(posedge clk) begin
		if (srst) begin
			awready    <= 1'b0;
			wready     <= 1'b0;
			arready    <= 1'b0;
			bvalid     <= 1'b0;
			rvalid     <= 1'b0;
			bresp      <= `RESP_OKAY;
			rresp      <= `RESP_OKAY;
			rdata      <= `RESET_WORD;
			awHave_reg <= 1'b0;
			wHave_reg  <= 1'b0;
			awHold_reg <= {`ADDR_W{1'b0}};
			wHold_reg  <= `RESET_WORD;
			sHold_reg  <= 4'h0;
		end else begin
			awready <= ~awHave_reg & ~awTake & ~bvalid;
			wready  <= ~wHave_reg & ~wTake & ~bvalid;
			if (awTake) begin
				awHave_reg <= 1'b1;
				awHold_reg <= awaddr;
			end
			if (wTake) begin
				wHave_reg <= 1'b1;
				wHold_reg <= wdata;
				sHold_reg <= wstrb;
			end
			if (wrFire) begin
				awHave_reg <= 1'b0;
				wHave_reg  <= 1'b0;
				bvalid     <= 1'b1;
				bresp      <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid & bready) begin
				bvalid <= 1'b0;
			end
			arready <= ~arready & ~rvalid & arvalid;
			if (arvalid & arready) begin
				rvalid <= 1'b1;
				rdata  <= rdOk ? rdWord : `RESET_WORD;
				rresp  <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid & rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule // axil_bus_slave

/* File: single_trip_delay_info_regs.v */
// single-trip delay information registers, slave or master variant
// assumes axi4-lite master on clk; link-side framing logic reads the control outputs
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/100ps
`include "delay_info_consts.vh"
module single_trip_delay_info_regs #(
	parameter IS_SLAVE = 1
) (
	input  wire               clk,
	input  wire               srst,
	input  wire [`ADDR_W-1:0] awaddr,
	input  wire               awvalid,
	output wire               awready,
	input  wire [31:0]        wdata,
	input  wire [3:0]         wstrb,
	input  wire               wvalid,
	output wire               wready,
	output wire [1:0]         bresp,
	output wire               bvalid,
	input  wire               bready,
	input  wire [`ADDR_W-1:0] araddr,
	input  wire               arvalid,
	output wire               arready,
	output wire [31:0]        rdata,
	output wire [1:0]         rresp,
	output wire               rvalid,
	input  wire               rready,
	input  wire [11:0]        linkTxDelay,
	input  wire               linkTxDelayValid,
	output reg  [7:0]         targetCycles,
	output reg  [8:0]         targetSteps,
	output reg                insertEnable,
	output reg  [6:0]         insertSeq,
	output reg  [7:0]         insertFrame,
	output reg                extractEnable,
	output reg  [6:0]         extractSeq,
	output reg  [7:0]         extractFrame,
	output reg  [11:0]        txDelayUsed,
	output reg                txDelayUsedValid
);
	wire               wrFire;
	wire [`ADDR_W-1:0] wrAddr;
	wire [31:0]        wrData;
	wire [3:0]         wrStrb;
	wire [`ADDR_W-1:0] rdAddr;
	wire [31:0]        targetWord;
	wire [31:0]        txLocWord;
	wire [31:0]        rxLocWord;
	wire [31:0]        ovrWord;
	reg  [31:0]        rdWord;
	reg                rdOk;
	reg                wrOk;
	wire               slaveSide = (IS_SLAVE != 0);
	// variant presence: absent registers answer slverr and never store
	function hit;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] off;
		input               present;
		begin
			hit = present & (a == off);
		end
	endfunction
	always @* begin
		wrOk = 1'b0;
		if (hit(wrAddr, `OFF_TARGET, slaveSide)) begin
			wrOk = 1'b1;
		end else if (hit(wrAddr, `OFF_TX_LOC, ~slaveSide)) begin
			wrOk = 1'b1;
		end else if (hit(wrAddr, `OFF_RX_LOC, slaveSide)) begin
			wrOk = 1'b1;
		end else if (hit(wrAddr, `OFF_OVERRIDE, slaveSide)) begin
			wrOk = 1'b1;
		end
	end
	always @* begin
		rdOk   = 1'b1;
		rdWord = `RESET_WORD;
		if (hit(rdAddr, `OFF_TARGET, slaveSide)) begin
			rdWord = targetWord;
		end else if (hit(rdAddr, `OFF_TX_LOC, ~slaveSide)) begin
			rdWord = txLocWord;
		end else if (hit(rdAddr, `OFF_RX_LOC, slaveSide)) begin
			rdWord = rxLocWord;
		end else if (hit(rdAddr, `OFF_OVERRIDE, slaveSide)) begin
			rdWord = ovrWord;
		end else begin
			rdOk = 1'b0;
		end
	end
	axil_bus_slave u_bus (
		.clk     (clk),
		.srst    (srst),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wrFire  (wrFire),
		.wrAddr  (wrAddr),
		.wrData  (wrData),
		.wrStrb  (wrStrb),
		.wrOk    (wrOk),
		.rdAddr  (rdAddr),
		.rdWord  (rdWord),
		.rdOk    (rdOk)
	);
	masked_word_reg #(.MASK(`MASK_TARGET)) u_target (
		.clk      (clk),
		.srst     (srst),
		.wrHit    (wrFire & hit(wrAddr, `OFF_TARGET, slaveSide)),
		.wrData   (wrData),
		.wrStrb   (wrStrb),
		.word_reg (targetWord)
	);
	masked_word_reg #(.MASK(`MASK_LOC)) u_txloc (
		.clk      (clk),
		.srst     (srst),
		.wrHit    (wrFire & hit(wrAddr, `OFF_TX_LOC, ~slaveSide)),
		.wrData   (wrData),
		.wrStrb   (wrStrb),
		.word_reg (txLocWord)
	);
	masked_word_reg #(.MASK(`MASK_LOC)) u_rxloc (
		.clk      (clk),
		.srst     (srst),
		.wrHit    (wrFire & hit(wrAddr, `OFF_RX_LOC, slaveSide)),
		.wrData   (wrData),
		.wrStrb   (wrStrb),
		.word_reg (rxLocWord)
	);
	masked_word_reg #(.MASK(`MASK_OVERRIDE)) u_override (
		.clk      (clk),
		.srst     (srst),
		.wrHit    (wrFire & hit(wrAddr, `OFF_OVERRIDE, slaveSide)),
		.wrData   (wrData),
		.wrStrb   (wrStrb),
		.word_reg (ovrWord)
	);
	wire ovrEn = ovrWord[`BIT_ENABLE];
	// control outputs registered once more so every top output is a flop
	always @(posedge clk) begin
		if (srst) begin
			targetCycles     <= 8'h00;
			targetSteps      <= 9'h000;
			insertEnable     <= 1'b0;
			insertSeq        <= 7'h00;
			insertFrame      <= 8'h00;
			extractEnable    <= 1'b0;
			extractSeq       <= 7'h00;
			extractFrame     <= 8'h00;
			txDelayUsed      <= 12'h000;
			txDelayUsedValid <= 1'b0;
		end else begin
			targetCycles  <= targetWord[`CYC_HI:`CYC_LO];
			targetSteps   <= targetWord[`STEP_HI:`STEP_LO];
			insertEnable  <= txLocWord[`BIT_ENABLE];
			insertSeq     <= txLocWord[`SEQ_HI:`SEQ_LO];
			insertFrame   <= txLocWord[`FRAME_HI:`FRAME_LO];
			// override wins; extraction is gated off while it is set
			extractEnable <= rxLocWord[`BIT_ENABLE] & ~ovrEn;
			extractSeq    <= rxLocWord[`SEQ_HI:`SEQ_LO];
			extractFrame  <= rxLocWord[`FRAME_HI:`FRAME_LO];
			if (ovrEn) begin
				txDelayUsed      <= ovrWord[`USR_HI:`USR_LO];
				txDelayUsedValid <= 1'b1;
			end else if (rxLocWord[`BIT_ENABLE] & linkTxDelayValid) begin
				txDelayUsed      <= linkTxDelay;
				txDelayUsedValid <= 1'b1;
			end else if (~rxLocWord[`BIT_ENABLE]) begin
				txDelayUsedValid <= 1'b0;
			end
		end
	end
endmodule // single_trip_delay_info_regs

/* File: delay_info_regs_monitor.sv */
// port checker for the delay information register bank
// assumes it is bound to the top module, bready and rready from the master
`timescale 1ns/100ps
`include "delay_info_consts.vh"
module delay_info_regs_monitor #(
	parameter IS_SLAVE = 1
) (
	input logic               clk,
	input logic               srst,
	input logic               awvalid,
	input logic               awready,
	input logic               bvalid,
	input logic               arvalid,
	input logic               arready,
	input logic [`ADDR_W-1:0] araddr,
	input logic               rvalid,
	input logic [31:0]        rdata,
	input logic [1:0]         rresp,
	input logic [7:0]         targetCycles,
	input logic [8:0]         targetSteps,
	input logic [6:0]         extractSeq,
	input logic [7:0]         extractFrame
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence ar_take(a);
		arvalid && arready && araddr == a;
	endsequence
	sequence aw_take;
		awvalid && awready;
	endsequence
	a_reset_zero: assert property ($past(srst) |-> {targetCycles, targetSteps} == 0)
		else $error("fields not clear after reset");
	a_aw_resp: assert property (aw_take |-> ##[1:3] bvalid)
		else $error("write not answered");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read not answered");
	a_ar_block: assert property (rvalid |-> !arready)
		else $error("address taken while answer pending");
	a_rsv_zero: assert property (rvalid |-> (rdata & 32'hfe00_8000) == 0)
		else $error("reserved bits read nonzero");
	// a field may only move right after a write answer; reset is the other cause
	a_ctrl_after_wr: assert property ($changed({targetCycles, extractSeq, extractFrame})
		|-> $past(bvalid) || $past(srst))
		else $error("field changed without write");
	if (IS_SLAVE) begin : g_slave
		a_absent_err: assert property (ar_take(`OFF_TX_LOC) |=> rresp == `RESP_SLVERR)
			else $error("absent register not refused");
		a_mapped_ok: assert property (ar_take(`OFF_TARGET) |=> rresp == `RESP_OKAY)
			else $error("present register refused");
	end
endmodule // delay_info_regs_monitor

/* File: link_peer_model.sv */
// far-end framing source of tx delay information
// assumes the peer inserts at the location that software gave the slave
`timescale 1ns/100ps
module link_peer_model (
	input  logic        clk,
	output logic [11:0] linkTxDelay,
	output logic        linkTxDelayValid
);
	initial begin
		linkTxDelay = 12'h000;
		linkTxDelayValid = 1'b0;
	end
	// one word per hyperframe slot; outside it the field shows junk, not the old value
	task send(input logic [11:0] v);
		@(posedge clk);
		linkTxDelay <= v;
		linkTxDelayValid <= 1'b1;
		@(posedge clk);
		linkTxDelay <= ~v;
		linkTxDelayValid <= 1'b0;
	endtask
endmodule // link_peer_model

/* File: single_trip_delay_info_regs_tb_top.sv */
// bench for the slave and master variants of the delay information registers
// assumes bready and rready held high, which the bus allows
`timescale 1ns/100ps
`include "delay_info_consts.vh"
module single_trip_delay_info_regs_tb_top;
	logic        clk, srst, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, linkTxDelayValid;
	logic        insertEnable, extractEnable, txDelayUsedValid;
	logic [7:0]  awaddr, araddr, targetCycles, insertFrame, extractFrame;
	logic [6:0]  insertSeq, extractSeq;
	logic [8:0]  targetSteps;
	logic [11:0] linkTxDelay, txDelayUsed;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, mBresp, mRresp;
	logic        mInsertEnable;
	logic [6:0]  mInsertSeq;
	logic [7:0]  mInsertFrame, mTargetCycles;
	logic [8:0]  mTargetSteps;
	int          mismatches, n_tests;
	single_trip_delay_info_regs #(.IS_SLAVE(1)) dut (.clk(clk), .srst(srst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .linkTxDelay(linkTxDelay),
		.linkTxDelayValid(linkTxDelayValid), .targetCycles(targetCycles),
		.targetSteps(targetSteps), .insertEnable(insertEnable), .insertSeq(insertSeq),
		.insertFrame(insertFrame), .extractEnable(extractEnable), .extractSeq(extractSeq),
		.extractFrame(extractFrame), .txDelayUsed(txDelayUsed),
		.txDelayUsedValid(txDelayUsedValid));
	// master variant shares the bus inputs; its handshake timing is the same logic as the slave's
	single_trip_delay_info_regs #(.IS_SLAVE(0)) dut_master (.clk(clk), .srst(srst),
		.awaddr(awaddr), .awvalid(awvalid), .awready(), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(), .bresp(mBresp), .bvalid(), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(), .rdata(), .rresp(mRresp),
		.rvalid(), .rready(rready), .linkTxDelay(linkTxDelay),
		.linkTxDelayValid(linkTxDelayValid), .targetCycles(mTargetCycles),
		.targetSteps(mTargetSteps), .insertEnable(mInsertEnable), .insertSeq(mInsertSeq),
		.insertFrame(mInsertFrame), .extractEnable(), .extractSeq(), .extractFrame(),
		.txDelayUsed(), .txDelayUsedValid());
	link_peer_model peer (.clk(clk), .linkTxDelay(linkTxDelay),
		.linkTxDelayValid(linkTxDelayValid));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		chk(32'(bresp), 32'(er));
		chk(32'(mBresp), (a == `OFF_TX_LOC) ? 32'(`RESP_OKAY) : 32'(`RESP_SLVERR));
		@(posedge clk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		chk(rdata, exp);
		chk(32'(rresp), 32'(er));
		chk(32'(mRresp), (a == `OFF_TX_LOC) ? 32'(`RESP_OKAY) : 32'(`RESP_SLVERR));
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// the whole sequence needs well under 500 cycles
	initial begin
		#20000;
		mismatches++;
		print_verdict;
	end
	initial begin
		{awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} = '0;
		bready = 1'b1;
		rready = 1'b1;
		srst = 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd(`OFF_TARGET, 32'h0000_0000, `RESP_OKAY);
		rd(`OFF_RX_LOC, 32'h0000_0000, `RESP_OKAY);
		rd(`OFF_TX_LOC, 32'h0000_0000, `RESP_SLVERR);
		rd(8'h80, 32'h0000_0000, `RESP_SLVERR);
		wr(`OFF_TX_LOC, 32'hffff_ffff, 4'hf, `RESP_SLVERR);
		chk(32'({insertEnable, insertSeq, insertFrame}), 32'h0000_0000);
		chk(32'({mInsertEnable, mInsertSeq, mInsertFrame}), 32'h0000_ffff);
		wr(`OFF_TARGET, 32'hffff_ffff, 4'hf, `RESP_OKAY);
		chk(32'({mTargetSteps, mTargetCycles}), 32'h0000_0000);
		rd(`OFF_TARGET, 32'h01ff_00ff, `RESP_OKAY);
		wr(`OFF_RX_LOC, 32'hffff_ffff, 4'hf, `RESP_OKAY);
		rd(`OFF_RX_LOC, 32'h0001_7fff, `RESP_OKAY);
		wr(`OFF_TARGET, 32'h0000_0000, 4'h1, `RESP_OKAY);
		rd(`OFF_TARGET, 32'h01ff_0000, `RESP_OKAY);
		chk(32'({targetSteps, targetCycles}), 32'h0001_ff00);
		// location the peer inserts at
		wr(`OFF_TX_LOC, 32'h0000_2a55, 4'hf, `RESP_SLVERR);
		chk(32'({mInsertEnable, mInsertSeq, mInsertFrame}), 32'h0000_2a55);
		wr(`OFF_TX_LOC, 32'h0001_2a55, 4'hf, `RESP_SLVERR);
		wr(`OFF_RX_LOC, 32'h0001_2a55, 4'hf, `RESP_OKAY);
		chk(32'({extractEnable, extractSeq, extractFrame}), 32'h0000_aa55);
		chk(32'({mInsertEnable, mInsertSeq, mInsertFrame}), 32'h0000_aa55);
		peer.send(12'habc);
		repeat (2) @(posedge clk);
		chk(32'({txDelayUsedValid, txDelayUsed}), 32'h0000_1abc);
		wr(`OFF_OVERRIDE, 32'hffff_f123, 4'hf, `RESP_OKAY);
		rd(`OFF_OVERRIDE, 32'h0001_0123, `RESP_OKAY);
		peer.send(12'h456);
		repeat (2) @(posedge clk);
		chk(32'(extractEnable), 32'h0000_0000);
		chk(32'({txDelayUsedValid, txDelayUsed}), 32'h0000_1123);
		wr(`OFF_OVERRIDE, 32'h0000_0000, 4'hf, `RESP_OKAY);
		chk(32'(extractEnable), 32'h0000_0001);
		// extraction off: a link word must not be taken up
		wr(`OFF_RX_LOC, 32'h0000_2a55, 4'hf, `RESP_OKAY);
		peer.send(12'h777);
		repeat (2) @(posedge clk);
		chk(32'({extractEnable, txDelayUsedValid}), 32'h0000_0000);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd(`OFF_RX_LOC, 32'h0000_0000, `RESP_OKAY);
		chk(32'({mInsertEnable, mInsertSeq, mInsertFrame}), 32'h0000_0000);
		print_verdict;
	end
endmodule // single_trip_delay_info_regs_tb_top
bind single_trip_delay_info_regs delay_info_regs_monitor #(.IS_SLAVE(IS_SLAVE)) mon (
	.clk(clk), .srst(srst), .awvalid(awvalid), .awready(awready), .bvalid(bvalid),
	.arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rdata(rdata),
	.rresp(rresp), .targetCycles(targetCycles), .targetSteps(targetSteps),
	.extractSeq(extractSeq), .extractFrame(extractFrame));
